// *** logic/ssd_scan_driver.v ***
// Operation
// RQ1 - Digit values go out on four data lines while four latch enables strobe in turn.
// RQ2 - The control code picks four or eight digits and the data and latch polarity.
// RQ3 - Codes 0-3 mean four digits, 4-7 eight; bit 0 inverts latches, bit 1 inverts data.
// RQ4 - Sources are BCD: one word holds four digits, two words hold eight.
// RQ5 - A round over all latches lasts 12 cycles and then restarts at once, forever.
// RQ6 - The one-round flag pulses one cycle in 12 after all latches, on bit 8 or bit 12.
// RQ7 - Four-digit mode drives data on bits 0-3 and latches 0-3 on bits 4-7.
// RQ8 - Eight-digit mode drives first-word digits on bits 0-3 and latches on bits 8-11.
// RQ9 - Eight-digit mode drives second-word digits on bits 4-7 alongside the first.
// RQ10 - Each new round samples the source words afresh and shows them for 12 cycles.
// RQ11 - Each activation begins at latch enable 0 at the start of a round.
// RQ12 - All four or eight digits are always driven whatever the display size.
// RQ13 - Software clears the scan state before first activation.
// RQ14 - No other party touches the scan state while the driver runs.
// RQ15 - Code 4 gives eight digits with polarity matching the output port.
// RQ16 - Each latch takes three cycles: data setup, latch high, latch release, in order.
// RQ17 - The error indication always stays low.
`include "ssd_defs.vh"

module ssd_scan_driver (
	input  wire                     clk,
	input  wire                     rst,
	input  wire                     enable,
	input  wire [`SSD_ADDR_W-1:0]   addr,
	input  wire [15:0]              wdata,
	input  wire                     wr_stb,
	input  wire                     rd_stb,
	output reg  [15:0]              rdata,
	output reg  [`SSD_OUT_W-1:0]    out_word,
	output wire                     error_indication,
	output wire                     irq
);

	reg  [`SSD_CTL_W-1:0]  ctl_r;
	reg  [15:0]            src0_r;
	reg  [15:0]            src1_r;
	reg  [15:0]            shown0_r;
	reg  [15:0]            shown1_r;
	reg  [`SSD_CTL_W-1:0]  act_ctl_r;
	reg                    run_r;
	reg  [`SSD_OUT_W-1:0]  out_nxt;
	reg  [15:0]            rd_nxt;
	reg  [3:0]             le_vec;
	reg  [3:0]             dig0;
	reg  [3:0]             dig1;
	wire [`SSD_CNT_W-1:0]  step_r;
	wire [`SSD_CNT_W-1:0]  le_full;
	wire [`SSD_CNT_W-1:0]  phase_full;
	wire                   round_end;
	wire                   start;
	wire [1:0]             le_idx;
	wire [1:0]             phase;
	wire [`SSD_EVT_W-1:0]  status_r;
	wire [`SSD_EVT_W-1:0]  mask_r;
	wire [`SSD_EVT_W-1:0]  events;

	assign error_indication = 1'b0; // RQ17
	assign start = enable && !run_r;

	// The scan state is hardware-owned and always reset, so RQ13 and RQ14
	// cannot disturb it; it is only readable for inspection.
	always @(posedge clk) begin
		if (rst)
			run_r <= 1'b0;
		else
			run_r <= enable;
	end

	ssd_step_counter u_step (
		.clk       (clk),
		.rst       (rst),
		.restart   (start),
		.run       (run_r),
		.step_r    (step_r),
		.round_end (round_end)
	);

	assign le_full = step_r / `SSD_STEPS_PER_LE; // RQ16
	assign phase_full = step_r % `SSD_STEPS_PER_LE;
	assign le_idx = le_full[1:0];
	assign phase = phase_full[1:0];

	// Snapshot at round start keeps digits steady across the whole round.
	always @(posedge clk) begin
		if (rst) begin
			shown0_r <= 16'h0000;
			shown1_r <= 16'h0000;
			act_ctl_r <= 3'h0;
		end else if (start || round_end) begin
			shown0_r <= src0_r; // RQ10
			shown1_r <= src1_r; // RQ4
			act_ctl_r <= ctl_r; // RQ2
		end
	end

	// A control write mid-round takes effect at the next round boundary.
	always @(posedge clk) begin
		if (rst) begin
			ctl_r <= 3'h0;
			src0_r <= 16'h0000;
			src1_r <= 16'h0000;
		end else if (wr_stb) begin
			if (addr == `SSD_REG_CTL)
				ctl_r <= wdata[`SSD_CTL_W-1:0];
			if (addr == `SSD_REG_SRC0)
				src0_r <= wdata;
			if (addr == `SSD_REG_SRC1)
				src1_r <= wdata;
		end
	end

	always @* begin
		le_vec = 4'h0;
		if (run_r && phase == 2'd1)
			le_vec[le_idx] = 1'b1; // RQ1
		dig0 = shown0_r[le_idx*4 +: 4];
		dig1 = shown1_r[le_idx*4 +: 4]; // RQ9
		if (act_ctl_r[`SSD_CTL_LATCH_INV])
			le_vec = ~le_vec; // RQ3
		if (act_ctl_r[`SSD_CTL_DATA_INV]) begin
			dig0 = ~dig0; // RQ3
			dig1 = ~dig1;
		end
		out_nxt = {`SSD_OUT_W{1'b0}};
		if (run_r) begin
			if (act_ctl_r[`SSD_CTL_EIGHT]) begin
				out_nxt[3:0] = dig0; // RQ8
				out_nxt[7:4] = dig1; // RQ12
				out_nxt[`SSD_LE8_LSB +: 4] = le_vec;
				out_nxt[`SSD_RND8_BIT] = round_end; // RQ6
			end else begin
				out_nxt[3:0] = dig0; // RQ7
				out_nxt[`SSD_LE4_LSB +: 4] = le_vec;
				out_nxt[`SSD_RND4_BIT] = round_end; // RQ6
			end
		end
	end

	always @(posedge clk) begin
		if (rst)
			out_word <= {`SSD_OUT_W{1'b0}};
		else
			out_word <= out_nxt;
	end

	assign events = {start, round_end};

	ssd_irq u_irq (
		.clk      (clk),
		.rst      (rst),
		.events   (events),
		.clr_wr   (wr_stb && (addr == `SSD_REG_STAT)),
		.mask_wr  (wr_stb && (addr == `SSD_REG_MASK)),
		.wdata    (wdata[`SSD_EVT_W-1:0]),
		.status_r (status_r),
		.mask_r   (mask_r),
		.irq      (irq)
	);

	always @* begin
		case (addr)
			`SSD_REG_CTL:   rd_nxt = {13'h0000, ctl_r};
			`SSD_REG_SRC0:  rd_nxt = src0_r;
			`SSD_REG_SRC1:  rd_nxt = src1_r;
			`SSD_REG_STAT:  rd_nxt = {14'h0000, status_r};
			`SSD_REG_MASK:  rd_nxt = {14'h0000, mask_r};
			`SSD_REG_STATE: rd_nxt = {11'h000, run_r, step_r};
			default:        rd_nxt = 16'h0000;
		endcase
	end

	always @(posedge clk) begin
		if (rst)
			rdata <= 16'h0000;
		else if (rd_stb)
			rdata <= rd_nxt;
		else
			rdata <= 16'h0000;
	end

endmodule // ssd_scan_driver

// *** pkg/ssd_defs.vh ***
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH

// Control code fields.
`define SSD_CTL_W          3
`define SSD_CTL_LATCH_INV  0
`define SSD_CTL_DATA_INV   1
`define SSD_CTL_EIGHT      2

// Round timing: four latches, three steps each.
`define SSD_STEPS_PER_LE   2'd3
`define SSD_ROUND_CYC      12
`define SSD_LAST_STEP      4'hB
`define SSD_CNT_W          4

// Output word positions.
`define SSD_OUT_W          16
`define SSD_LE4_LSB        4
`define SSD_LE8_LSB        8
`define SSD_RND4_BIT       8
`define SSD_RND8_BIT       12

// Register offsets and interrupt event bits.
`define SSD_ADDR_W         4
`define SSD_REG_CTL        4'h0
`define SSD_REG_SRC0       4'h1
`define SSD_REG_SRC1       4'h2
`define SSD_REG_STAT       4'h3
`define SSD_REG_MASK       4'h4
`define SSD_REG_STATE      4'h5
`define SSD_EVT_W          2
`define SSD_EVT_ROUND      0
`define SSD_EVT_START      1

`endif

// *** logic/ssd_step_counter.v ***
`include "ssd_defs.vh"

module ssd_step_counter (
	input  wire                   clk,
	input  wire                   rst,
	input  wire                   restart,
	input  wire                   run,
	output reg  [`SSD_CNT_W-1:0]  step_r,
	output wire                   round_end
);

	reg [`SSD_CNT_W-1:0] step_nxt;

	assign round_end = run && (step_r == `SSD_LAST_STEP);

	always @* begin
		step_nxt = step_r;
		if (restart)
			step_nxt = {`SSD_CNT_W{1'b0}}; // RQ11
		else if (run)
			step_nxt = round_end ? {`SSD_CNT_W{1'b0}} : // RQ5
				step_r + 4'h1;
	end

	always @(posedge clk) begin
		if (rst)
			step_r <= {`SSD_CNT_W{1'b0}};
		else
			step_r <= step_nxt;
	end

endmodule // ssd_step_counter

// *** logic/ssd_irq.v ***
`include "ssd_defs.vh"

module ssd_irq (
	input  wire                   clk,
	input  wire                   rst,
	input  wire [`SSD_EVT_W-1:0]  events,
	input  wire                   clr_wr,
	input  wire                   mask_wr,
	input  wire [`SSD_EVT_W-1:0]  wdata,
	output reg  [`SSD_EVT_W-1:0]  status_r,
	output reg  [`SSD_EVT_W-1:0]  mask_r,
	output wire                   irq
);

	genvar i;

	// A new event beats a write-one-to-clear in the same cycle.
	generate
		for (i = 0; i < `SSD_EVT_W; i = i + 1) begin : g_evt
			always @(posedge clk) begin
				if (rst)
					status_r[i] <= 1'b0;
				else if (events[i])
					status_r[i] <= 1'b1;
				else if (clr_wr && wdata[i])
					status_r[i] <= 1'b0;
			end
		end
	endgenerate

	always @(posedge clk) begin
		if (rst)
			mask_r <= {`SSD_EVT_W{1'b0}};
		else if (mask_wr)
			mask_r <= wdata;
	end

	assign irq = |(status_r & mask_r);

endmodule // ssd_irq

// *** tb/ssd_disp_model.sv ***
module ssd_disp_model (
	input wire        clk,
	input wire [15:0] out_word,
	input wire [2:0]  ctl,
	output reg [31:0] disp
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [3:0] le = (ctl[2] ? out_word[11:8] : out_word[7:4]) ^ {4{ctl[0]}};
	wire [7:0] d = out_word[7:0] ^ {8{ctl[1]}};
	reg  [3:0] pv = 4'h0;
	// A digit is caught on the leading edge of its own latch line only.
	always @(posedge clk) begin
		pv <= le;
		for (int k = 0; k < 4; k++)
			if (le[k] && !pv[k]) begin
				disp[k*4+:4] <= d[3:0];
				disp[k*4+16+:4] <= d[7:4];
			end
	end
endmodule // ssd_disp_model

// *** tb/ssd_scan_driver_sva.sv ***
module ssd_scan_driver_sva (
	input wire        clk, rst, enable, wr_stb, rd_stb,
	input wire [3:0]  addr,
	input wire [15:0] wdata, rdata, out_word,
	input wire        error_indication, irq
);
	reg  [2:0] c;
	reg        q1, q2;
	reg  [3:0] ph;
	wire       v = q1 && q2;
	wire [3:0] le = (c[2] ? out_word[11:8] : out_word[7:4]) ^ {4{c[0]}};
	wire [3:0] ex = (ph % 3 == 1) ? 4'h1 << (ph / 3) : 4'h0;
	wire       fl = c[2] ? out_word[12] : out_word[8];
	wire [7:0] dt = c[2] ? out_word[7:0] : {4'h0, out_word[3:0]};
	// The shadow code is exact only because it is written while stopped.
	always @(posedge clk) begin
		c <= rst ? 3'h0 : (wr_stb && addr == 4'h0) ? wdata[2:0] : c;
		q1 <= !rst && enable;
		q2 <= !rst && q1;
		ph <= (!q2 || ph == 4'hB) ? 4'h0 : ph + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_err; !error_indication; endproperty
	a_err: assert property (p_err) else $error("error set");
	property p_off; !enable |-> ##2 out_word == 16'h0; endproperty
	a_off: assert property (p_off) else $error("not idle");
	property p_lat; v |-> le == ex; endproperty
	a_lat: assert property (p_lat) else $error("latch order");
	property p_flag; v |-> fl == (ph == 4'hB); endproperty
	a_flag: assert property (p_flag) else $error("round flag");
	property p_hold; v && ph % 3 != 0 |-> $stable(dt); endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_top; v |-> out_word >> (c[2] ? 13 : 9) == 16'h0; endproperty
	a_top: assert property (p_top) else $error("stray bit");
	property p_start; $rose(q2) |-> le == 4'h0 ##1 le == 4'h1; endproperty
	a_start: assert property (p_start) else $error("bad start");
	property p_rd; !rd_stb |=> rdata == 16'h0; endproperty
	a_rd: assert property (p_rd) else $error("stray rdata");
	c_round: cover property (v && fl);
	c_eight: cover property (v && c[2] && fl);
	c_inv: cover property (v && c[0] && c[1]);
endmodule // ssd_scan_driver_sva

bind ssd_scan_driver ssd_scan_driver_sva i_sva (.clk(clk), .rst(rst),
	.enable(enable), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
	.rd_stb(rd_stb), .rdata(rdata), .out_word(out_word),
	.error_indication(error_indication), .irq(irq));

// *** tb/ssd_scan_driver_tb.sv ***
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end

module ssd_scan_driver_tb;
	timeunit 1ns;
	timeprecision 1ns;
	reg         clk = 1'b0, rst = 1'b1, enable = 1'b0;
	reg         wr_stb = 1'b0, rd_stb = 1'b0;
	reg  [3:0]  addr = 4'h0;
	reg  [15:0] wdata = 16'h0;
	reg  [2:0]  ctl = 3'h0;
	wire [15:0] rdata, out_word;
	wire [31:0] disp;
	wire        err, irq;
	int         miscompares = 0, compares = 0;
	ssd_scan_driver i_dut (.clk(clk), .rst(rst), .enable(enable),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .out_word(out_word), .error_indication(err),
		.irq(irq));
	ssd_disp_model i_disp (.clk(clk), .out_word(out_word), .ctl(ctl),
		.disp(disp));
	initial forever #10 clk = ~clk;
	task automatic wr(input [3:0] a, input [15:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input [3:0] a, input [15:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
		@(posedge clk);
	endtask
	task automatic t_code(input [2:0] c);
		ctl <= c;
		wr(4'h0, {13'h0, c});
		wr(4'h1, {12'h905, 1'b0, c});
		wr(4'h2, 16'h2468);
		enable <= 1'b1;
		repeat (15) @(posedge clk);
		#1;
		`CHK("low", {12'h905, 1'b0, c}, disp[15:0])
		if (c[2])
			`CHK("high", 16'h2468, disp[31:16])
		@(posedge clk);
		enable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_fresh;
		ctl <= 3'h4;
		wr(4'h0, 16'h0004);
		wr(4'h1, 16'h1111);
		enable <= 1'b1;
		repeat (3) @(posedge clk);
		wr(4'h1, 16'h7777);
		repeat (8) @(posedge clk);
		#1;
		`CHK("old", 4'h1, disp[15:12])
		repeat (14) @(posedge clk);
		#1;
		`CHK("new", 16'h7777, disp[15:0])
		@(posedge clk);
		enable <= 1'b0;
		@(posedge clk);
		enable <= 1'b1;
		repeat (9) @(posedge clk);
		enable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_irq;
		#1;
		`CHK("masked", 1'b0, irq)
		@(posedge clk);
		wr(4'h4, 16'h0001);
		#1;
		`CHK("irq on", 1'b1, irq)
		@(posedge clk);
		rd(4'h3, 16'h0003);
		wr(4'h3, 16'h0003);
		rd(4'h3, 16'h0000);
		`CHK("irq off", 1'b0, irq)
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000);
	endtask
	task report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Whole run is a few hundred cycles; this limit only catches a hang.
	initial begin
		#20000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(4'h5, 16'h0000);
		for (int i = 0; i < 8; i++)
			t_code(i[2:0]);
		t_fresh;
		t_irq;
		`CHK("err", 1'b0, err)
		report_and_stop;
	end
endmodule // ssd_scan_driver_tb
